// ==== npt_core.sv ====
// execution of the four nibble pair transfer instructions
`timescale 1ns/1ps
module npt_core (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  // instruction issue
  input  wire logic                      instr_valid,
  input  wire logic [9:0]                instr_word,
  input  wire logic [npt_pkg::PC_W-1:0]  pc_in,
  // sources
  input  wire logic [7:0]                timer_four_count,
  input  wire logic [9:0]                conv_result,
  input  wire logic [3:0]                conv_control_reg,
  input  wire logic [7:0]                spill_pair,
  input  wire logic [3:0]                acc_in,
  input  wire logic [2:0]                rom_pointer_in,
  // rom port
  output logic      [npt_pkg::PC_W-1:0]  rom_addr,
  input  wire logic [9:0]                rom_data,
  // results
  output logic      [3:0]                acc_out,
  output logic      [3:0]                high_half_out,
  output logic      [2:0]                rom_pointer_bits,
  output logic                           acc_b_we,
  output logic                           pointer_we,
  output logic                           busy,
  output logic                           done,
  output logic      [npt_pkg::SP_W-1:0]  stack_pointer,
  output logic      [npt_pkg::PC_W-1:0]  program_counter,
  output logic                           carry_we,
  output logic                           skip_next
);
  npt_pkg::npt_state_e      state_r;
  npt_pkg::npt_state_e      state_nxt;
  logic [npt_pkg::PC_W-1:0] saved_pc;
  logic [npt_pkg::PC_W-1:0] table_pc;
  logic [npt_pkg::SP_W-1:0] push_slot;
  logic                     push_en;
  logic                     single_en;
  logic                     load_now;
  logic [7:0]               pair_nxt;

  // ********************************
  // decode helpers
  // ********************************
  function automatic logic is_table(input logic [9:0] w);
    is_table = (w[9:6] == npt_pkg::OP_READ_ROM_TABLE);
  endfunction

  // single-cycle transfers need all ten bits to match
  function automatic logic is_single(input logic [9:0] w);
    is_single = (w == npt_pkg::OP_READ_TIMER_FOUR)
             || (w == npt_pkg::OP_READ_CONVERSION)
             || (w == npt_pkg::OP_READ_SPILL_PAIR);
  endfunction

  // page on top, pointer and accumulator below, all thirteen bits used
  function automatic logic [npt_pkg::PC_W-1:0] table_addr(
    input logic [5:0] page,
    input logic [2:0] ptr,
    input logic [3:0] acc
  );
    table_addr = {page, ptr, acc};
  endfunction

  // mode one keeps the low byte, mode zero drops the two lsbs
  function automatic logic [7:0] conv_pair(
    input logic [9:0] res,
    input logic       cmp
  );
    if (cmp) begin
      conv_pair = res[7:0];
    end else begin
      conv_pair = res[9:2];
    end
  endfunction

  assign push_en   = instr_valid && (state_r == npt_pkg::NPT_IDLE)
                     && is_table(instr_word);
  assign single_en = instr_valid && (state_r == npt_pkg::NPT_IDLE)
                     && is_single(instr_word);
  assign load_now  = (state_r == npt_pkg::NPT_LOAD);
  assign push_slot = stack_pointer + 3'h1;
  assign table_pc  = table_addr(instr_word[5:0], rom_pointer_in, acc_in);

  // source byte for the one-cycle transfers
  always_comb begin
    pair_nxt = 8'h00;
    case (instr_word)
      npt_pkg::OP_READ_TIMER_FOUR: begin
        pair_nxt = timer_four_count;
      end
      npt_pkg::OP_READ_CONVERSION: begin
        pair_nxt = conv_pair(conv_result,
          conv_control_reg[npt_pkg::COMPARE_MODE_POS]);
      end
      npt_pkg::OP_READ_SPILL_PAIR: begin
        pair_nxt = spill_pair;
      end
      default: begin
        pair_nxt = 8'h00;
      end
    endcase
  end

  // one level of the store is borrowed; overflow is software's job
  npt_stack_mem u_stack (
    .mclk    (mclk),
    .wr_en   (push_en),
    .wr_addr (push_slot),
    .wr_data (pc_in),
    .rd_addr (stack_pointer),
    .rd_data (saved_pc)
  );

  // ********************************
  // sequencer
  // ********************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      npt_pkg::NPT_IDLE: begin
        if (push_en) begin
          state_nxt = npt_pkg::NPT_FETCH;
        end
      end
      npt_pkg::NPT_FETCH: state_nxt = npt_pkg::NPT_LOAD;
      npt_pkg::NPT_LOAD:  state_nxt = npt_pkg::NPT_IDLE;
      default:            state_nxt = npt_pkg::NPT_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= npt_pkg::NPT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_nxt != npt_pkg::NPT_IDLE);
    end
  end

  // ********************************
  // stack and program counter
  // ********************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_pointer <= npt_pkg::SP_RST;
    end else if (push_en) begin
      stack_pointer <= push_slot;
    end else if (load_now) begin
      stack_pointer <= stack_pointer - 3'h1;
    end
  end

  // pc points at the table word while the fetch runs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      program_counter <= npt_pkg::PC_RST;
    end else if (push_en) begin
      program_counter <= table_pc;
    end else if (load_now) begin
      program_counter <= saved_pc;
    end
  end

  // rom word must stand at the edge that leaves the load state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rom_addr <= npt_pkg::PC_RST;
    end else if (push_en) begin
      rom_addr <= table_pc;
    end
  end

  // ********************************
  // register loads
  // ********************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      high_half_out <= npt_pkg::NIB_RST;
    end else if (load_now) begin
      high_half_out <= rom_data[7:4];
    end else if (single_en) begin
      high_half_out <= pair_nxt[7:4];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_out <= npt_pkg::NIB_RST;
    end else if (load_now) begin
      acc_out <= rom_data[3:0];
    end else if (single_en) begin
      acc_out <= pair_nxt[3:0];
    end
  end

  // the top pointer bit is always cleared by the table read
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rom_pointer_bits <= npt_pkg::PTR_RST;
    end else if (load_now) begin
      rom_pointer_bits <= {1'b0, rom_data[9:8]};
    end
  end

  // strobes last one cycle; requests while busy raise none
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_b_we <= 1'b0;
      done     <= 1'b0;
    end else begin
      acc_b_we <= load_now || single_en;
      done     <= load_now || single_en;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pointer_we <= 1'b0;
    end else begin
      pointer_we <= load_now;
    end
  end

  // none of these instructions touch carry or skip
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      carry_we  <= 1'b0;
      skip_next <= 1'b0;
    end else begin
      carry_we  <= 1'b0;
      skip_next <= 1'b0;
    end
  end
endmodule

// ==== npt_pkg.sv ====
// constants for the nibble pair transfer execution block
// Behaviour
// - opcode 1001110011 reads timer four, one cycle
// - timer high nibble to b, low to a
// - opcode 1001111001 reads conversion result, one cycle
// - mode zero: result 9..6 to b, 5..2 to a
// - mode one: result 7..4 to b, 3..0 to a
// - mode taken from control register bit 3
// - opcode 0000101010 reads spill pair, one cycle
// - spill high nibble to b, low to a
// - 0010 plus page reads rom table, three cycles
// - rom word unpacked into pointer, b and a
// - push pc, fetch, restore pc, pop pointer
package npt_pkg;
  localparam logic [9:0] OP_READ_TIMER_FOUR = 10'h273;
  localparam logic [9:0] OP_READ_CONVERSION = 10'h279;
  localparam logic [9:0] OP_READ_SPILL_PAIR = 10'h02A;
  localparam logic [3:0] OP_READ_ROM_TABLE  = 4'h2;
  localparam int         COMPARE_MODE_POS   = 3;
  localparam int         PC_W               = 13;
  localparam int         SP_W               = 3;
  localparam int         STACK_DEPTH        = 8;
  localparam logic [3:0] NIB_RST            = 4'h0;
  localparam logic [2:0] PTR_RST            = 3'h0;
  localparam logic [PC_W-1:0] PC_RST        = 13'h0000;
  localparam logic [SP_W-1:0] SP_RST        = 3'h7;

  typedef enum logic [1:0] {
    NPT_IDLE  = 2'b00,
    NPT_FETCH = 2'b01,
    NPT_LOAD  = 2'b10
  } npt_state_e;
endpackage

// ==== npt_stack_mem.sv ====
// return address stack store with registered read port
`timescale 1ns/1ps
module npt_stack_mem (
  // clock
  input  wire logic                        mclk,
  // write port
  input  wire logic                        wr_en,
  input  wire logic [npt_pkg::SP_W-1:0]    wr_addr,
  input  wire logic [npt_pkg::PC_W-1:0]    wr_data,
  // read port
  input  wire logic [npt_pkg::SP_W-1:0]    rd_addr,
  output logic      [npt_pkg::PC_W-1:0]    rd_data
);
  logic [npt_pkg::PC_W-1:0] mem_r [npt_pkg::STACK_DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= mem_r[rd_addr];
  end
endmodule

// ==== npt_core_chk.sv ====
// port assertions for the nibble pair transfer core
`timescale 1ns/1ps
module npt_core_chk (
  // stimulus
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [7:0] timer_four_count,
  input wire logic [9:0] conv_result,
  input wire logic [3:0] conv_control_reg,
  input wire logic [7:0] spill_pair,
  input wire logic [9:0] rom_data,
  // results
  input wire logic [3:0] acc_out,
  input wire logic [3:0] high_half_out,
  input wire logic [2:0] rom_pointer_bits,
  input wire logic       acc_b_we,
  input wire logic       pointer_we,
  input wire logic       busy,
  input wire logic       done,
  input wire logic [2:0] stack_pointer,
  input wire logic       carry_we,
  input wire logic       skip_next
);
  // ****************
  // checks
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic       go, t4, cv, sx, rt;
  logic [7:0] ab;
  assign go = instr_valid && !busy;
  assign t4 = go && instr_word == npt_pkg::OP_READ_TIMER_FOUR;
  assign cv = go && instr_word == npt_pkg::OP_READ_CONVERSION;
  assign sx = go && instr_word == npt_pkg::OP_READ_SPILL_PAIR;
  assign rt = go && instr_word[9:6] == npt_pkg::OP_READ_ROM_TABLE;
  assign ab = {high_half_out, acc_out};
  // an early done here means a request slipped in while busy
  sequence s_tab_run;
    (busy && !done) [*2] ##1 (done && pointer_we && acc_b_we && !busy);
  endsequence
  a_timer_read: assert property (t4 |=>
    done && acc_b_we && ab == $past(timer_four_count)) else $error("timer");
  a_conv_adc: assert property (cv && !conv_control_reg[3] |=>
    done && ab == 8'($past(conv_result) >> 2)) else $error("conv mode 0");
  a_conv_cmp: assert property (cv && conv_control_reg[3] |=>
    done && ab == 8'($past(conv_result))) else $error("conv mode 1");
  a_spill_read: assert property (sx |=>
    done && ab == $past(spill_pair)) else $error("spill read");
  a_tab_steps: assert property (rt |=> s_tab_run)
    else $error("table timing");
  a_tab_unpack: assert property (done && pointer_we |->
    {rom_pointer_bits, ab} == {1'b0, $past(rom_data)}) else $error("unpack");
  a_stack_use: assert property (rt |=>
    stack_pointer == $past(stack_pointer) + 3'h1 ##2
    stack_pointer == $past(stack_pointer, 3)) else $error("stack level");
  a_flags_quiet: assert property (!carry_we && !skip_next)
    else $error("flag touched");
endmodule
bind npt_core npt_core_chk i_npt_core_chk (.mclk, .sys_rst, .instr_valid,
  .instr_word, .timer_four_count, .conv_result, .conv_control_reg,
  .spill_pair, .rom_data, .acc_out, .high_half_out, .rom_pointer_bits,
  .acc_b_we, .pointer_we, .busy, .done, .stack_pointer, .carry_we,
  .skip_next);

// ==== npt_core_tb.sv ====
// random bench for the nibble pair transfer core
`timescale 1ns/1ps
module npt_core_tb;
  logic        mclk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
  logic [9:0]  instr_word = 10'h000, conv_result = 10'h000;
  logic [9:0]  rom_data = 10'h000;
  logic [12:0] pc_in = 13'h0000, rom_addr, program_counter;
  logic [7:0]  timer_four_count = 8'h00, spill_pair = 8'h00, held = 8'h00;
  logic [3:0]  conv_control_reg = 4'h0, acc_in = 4'h0, acc_out, high_half_out;
  logic [2:0]  rom_pointer_in = 3'h0, rom_pointer_bits, stack_pointer;
  logic        acc_b_we, pointer_we, busy, done, carry_we, skip_next;
  int          err_total = 0, checks_done = 0;
  npt_core i_npt_core (.mclk, .sys_rst, .instr_valid, .instr_word, .pc_in,
    .timer_four_count, .conv_result, .conv_control_reg, .spill_pair, .acc_in,
    .rom_pointer_in, .rom_addr, .rom_data, .acc_out, .high_half_out,
    .rom_pointer_bits, .acc_b_we, .pointer_we, .busy, .done, .stack_pointer,
    .program_counter, .carry_we, .skip_next);
  // ****************
  // tasks
  // ****************
  always #10 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] pick(input logic [9:0] op);
    if (op == npt_pkg::OP_READ_TIMER_FOUR) return timer_four_count;
    if (op == npt_pkg::OP_READ_SPILL_PAIR) return spill_pair;
    if (conv_control_reg[3]) return conv_result[7:0];
    return conv_result[9:2];
  endfunction
  // a refused opcode must leave the last result standing
  task automatic one_op(input logic [9:0] op, input logic hit);
    @(negedge mclk);
    {timer_four_count, spill_pair, conv_result} = 26'($urandom);
    conv_control_reg = 4'($urandom);
    instr_word = op;
    instr_valid = 1'b1;
    @(negedge mclk);
    instr_valid = 1'b0;
    if (hit) held = pick(op);
    chk(32'({carry_we, skip_next, pointer_we, acc_b_we, done}),
      32'({3'b000, hit, hit}));
    chk(32'(ab()), 32'(held));
  endtask
  function automatic logic [7:0] ab();
    return {high_half_out, acc_out};
  endfunction
  task automatic tab_op(input logic [5:0] pg);
    logic [9:0] rw;
    rw = 10'($urandom);
    @(negedge mclk);
    {pc_in, acc_in, rom_pointer_in} = 20'($urandom);
    instr_word = {npt_pkg::OP_READ_ROM_TABLE, pg};
    instr_valid = 1'b1;
    @(negedge mclk);
    instr_word = npt_pkg::OP_READ_TIMER_FOUR;
    @(negedge mclk);
    chk(32'({busy, done, acc_b_we}), 32'(3'b100));
    chk(32'(stack_pointer), 32'(3'h0));
    chk(32'(rom_addr), 32'({pg, rom_pointer_in, acc_in}));
    rom_data = rw;
    @(negedge mclk);
    rom_data = ~rw;
    instr_valid = 1'b0;
    held = rw[7:0];
    chk(32'({done, pointer_we, acc_b_we, busy}), 32'(4'he));
    chk(32'({stack_pointer, program_counter}), 32'({3'h7, pc_in}));
    chk(32'({rom_pointer_bits, ab()}), 32'({1'b0, rw}));
  endtask
  initial begin
    logic [9:0] ops [4];
    ops = '{npt_pkg::OP_READ_TIMER_FOUR, npt_pkg::OP_READ_CONVERSION,
      npt_pkg::OP_READ_SPILL_PAIR, 10'h3ff};
    void'($urandom(32'h6747));
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    tab_op(6'h00);
    tab_op(6'h2f);
    tab_op(6'h3f);
    for (int i = 0; i < 60; i++) begin
      if (i % 5 == 4) tab_op(6'($urandom));
      else one_op(ops[i % 4], i % 4 != 3);
    end
    stop_test;
  end
  initial begin
    repeat (2000) @(posedge mclk);
    err_total++;
    stop_test;
  end
endmodule
